// *** lcd_port_pkg.sv ***
package lcd_port_pkg;
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int SER_BITS   = 8;
  localparam int PIN_W      = 16;
  // positions in the synchronised pin vector
  localparam int PIN_D_LO   = 0;
  localparam int PIN_WR     = 8;
  localparam int PIN_RD     = 9;
  localparam int PIN_CSH    = 10;
  localparam int PIN_CSL    = 11;
  localparam int PIN_PAR    = 12;
  localparam int PIN_FLAV   = 13;
  localparam int PIN_DC     = 14;
  localparam int PIN_MRST_N = 15;
  // serial pins inside the data bus
  localparam int SER_CLK_BIT = 6;
  localparam int SER_DAT_BIT = 7;
  localparam logic [PIN_W-1:0] PIN_RST = 16'h8F00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] CNT_RST  = 4'h0;

  typedef struct packed {
    logic             dc;
    logic [DATA_W-1:0] data;
  } xfer_t;
  localparam int XFER_W = $bits(xfer_t);

  typedef enum logic [1:0] {
    PS_IDLE  = 2'b00,
    PS_READ  = 2'b01,
    PS_WRITE = 2'b10
  } port_state_t;
endpackage

// *** lcd_module_host_port.sv ***
`timescale 1ns/1ps
`default_nettype none

module xfer_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  input  wire logic             flush_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    wp_nxt;
  logic [AW-1:0]    rp_r;
  logic [AW-1:0]    rp_nxt;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             push;
  logic             pop;

  assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem_r[rp_r];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  always_comb begin
    wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
    if (flush_in) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
endmodule

// Contract
// - act only when both chip selects active
// - low reset pin level clears internal state
// - select high means display data
// - select low means command or status
// - separate mode latches on write strobe rise
// - enable mode direction high read, low write
// - separate mode drives bus while read low
// - enable pulse clocks each transfer
// - eight bit bidirectional parallel data bus
// - serial mode floats data pins 0 to 5
// - serial mode: pin 6 clock, pin 7 data
// - deselected chip floats all data pins
// - select and direction decode transfer type
module lcd_module_host_port
  import lcd_port_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  // clocks and reset
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  input  wire logic              link_clk_in,
  // host pins
  input  wire logic              chip_select_low_in,
  input  wire logic              chip_select_high_in,
  input  wire logic              module_reset_n_in,
  input  wire logic              data_command_sel_in,
  input  wire logic              bus_flavor_sel_in,
  input  wire logic              parallel_sel_in,
  input  wire logic              rd_enable_in,
  input  wire logic              wr_dir_in,
  input  wire logic [DATA_W-1:0] bus_d_in,
  output logic      [DATA_W-1:0] bus_d_out,
  output logic      [DATA_W-1:0] bus_d_oe_out,
  // written bytes towards the display core
  output logic                   wr_valid_out,
  input  wire logic              wr_ready_in,
  output logic                   wr_dc_out,
  output logic      [DATA_W-1:0] wr_data_out,
  // read side
  input  wire logic [DATA_W-1:0] disp_data_in,
  input  wire logic [DATA_W-1:0] status_in,
  output logic                   rd_strobe_out,
  output logic                   rd_dc_out,
  // state
  output logic                   busy_out,
  output logic                   module_in_reset_out
);
  // ---------------- link domain: serial receiver
  logic              link_rst;
  logic [DATA_W-1:0] ser_sh_r;
  logic [DATA_W-1:0] ser_sh_nxt;
  logic [3:0]        ser_cnt_r;
  logic [3:0]        ser_cnt_nxt;
  xfer_t             ser_hold_r;
  xfer_t             ser_hold_nxt;
  logic              ser_tog_r;
  logic              ser_tog_nxt;

  // receiver runs only while selected in serial mode; pin 6 toggles freely in parallel mode
  assign link_rst = sys_rst_in | chip_select_low_in | ~chip_select_high_in |
                    parallel_sel_in | ~module_reset_n_in;

  always_comb begin
    ser_sh_nxt   = {ser_sh_r[DATA_W-2:0], bus_d_in[SER_DAT_BIT]};
    ser_cnt_nxt  = 4'(ser_cnt_r + 1'b1);
    ser_hold_nxt = ser_hold_r;
    ser_tog_nxt  = ser_tog_r;
    if (ser_cnt_r == 4'(SER_BITS - 1)) begin
      ser_cnt_nxt       = CNT_RST;
      ser_hold_nxt.data = ser_sh_nxt;
      ser_hold_nxt.dc   = data_command_sel_in;
      ser_tog_nxt       = ~ser_tog_r;
    end
  end

  always_ff @(posedge link_clk_in or posedge link_rst) begin
    if (link_rst) begin
      ser_sh_r  <= BYTE_RST;
      ser_cnt_r <= CNT_RST;
    end else begin
      ser_sh_r  <= ser_sh_nxt;
      ser_cnt_r <= ser_cnt_nxt;
    end
  end

  // hold and toggle survive deselect so the last byte still crosses
  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ser_hold_r <= '0;
      ser_tog_r  <= 1'b0;
    end else begin
      ser_hold_r <= ser_hold_nxt;
      ser_tog_r  <= ser_tog_nxt;
    end
  end

  // ---------------- system domain: pin synchronisers
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic [PIN_W-1:0] pin_prev_r;
  logic [2:0]       tog_sync_r;

  assign pin_raw = {module_reset_n_in, data_command_sel_in, bus_flavor_sel_in,
                    parallel_sel_in, chip_select_low_in, chip_select_high_in,
                    rd_enable_in, wr_dir_in, bus_d_in};

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_s1_r   <= PIN_RST;
      pin_s2_r   <= PIN_RST;
      pin_prev_r <= PIN_RST;
      tog_sync_r <= 3'h0;
    end else begin
      pin_s1_r   <= pin_raw;
      pin_s2_r   <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
      tog_sync_r <= {tog_sync_r[1:0], ser_tog_r};
    end
  end

  // ---------------- decode of the parallel port
  logic  selected;
  logic  par_mode;
  logic  mod_rst;
  logic  rd_act;
  logic  par_write;
  logic  ser_event;
  xfer_t par_word;

  assign mod_rst  = ~pin_s2_r[PIN_MRST_N];
  assign selected = ~pin_s2_r[PIN_CSL] & pin_s2_r[PIN_CSH];
  assign par_mode = pin_s2_r[PIN_PAR];
  assign par_word = '{dc: pin_s2_r[PIN_DC], data: pin_s2_r[PIN_D_LO +: DATA_W]};

  always_comb begin
    if (pin_s2_r[PIN_FLAV]) begin
      rd_act      = pin_s2_r[PIN_RD] & pin_s2_r[PIN_WR];
      par_write   = pin_prev_r[PIN_RD] & ~pin_s2_r[PIN_RD] & ~pin_prev_r[PIN_WR];
    end else begin
      rd_act      = ~pin_s2_r[PIN_RD];
      par_write   = ~pin_prev_r[PIN_WR] & pin_s2_r[PIN_WR];
    end
    rd_act      = rd_act & selected & par_mode;
    par_write   = par_write & selected & par_mode & ~mod_rst;
  end

  assign ser_event = (tog_sync_r[2] != tog_sync_r[1]) & ~par_mode & ~mod_rst;

  // ---------------- transfer state and bus drivers
  port_state_t       st_r;
  port_state_t       st_nxt;
  logic [DATA_W-1:0] dout_nxt;
  logic [DATA_W-1:0] oe_nxt;
  logic              rdstb_nxt;
  logic              rddc_nxt;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  xfer_t             fifo_in_word;
  xfer_t             fifo_out_word;
  logic              fifo_out_valid;

  always_comb begin
    st_nxt    = st_r;
    dout_nxt  = bus_d_out;
    rdstb_nxt = 1'b0;
    rddc_nxt  = rd_dc_out;
    case (st_r)
      PS_IDLE: begin
        // level start: a read held low across select or module reset is still served
        if (rd_act && !mod_rst) begin
          st_nxt    = PS_READ;
          rdstb_nxt = 1'b1;
          rddc_nxt  = pin_s2_r[PIN_DC];
          dout_nxt  = pin_s2_r[PIN_DC] ? disp_data_in : status_in;
        end else if (par_write || ser_event) begin
          st_nxt = PS_WRITE;
        end
      end
      PS_READ: begin
        if (!rd_act) begin
          st_nxt = PS_IDLE;
        end
      end
      PS_WRITE: st_nxt = PS_IDLE;
      default:  st_nxt = PS_IDLE;
    endcase
    if (mod_rst) begin
      st_nxt = PS_IDLE;
    end
    // only a selected parallel read drives; else all pins float
    oe_nxt = (st_nxt == PS_READ && rd_act) ? {DATA_W{1'b1}} : '0;
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r          <= PS_IDLE;
      bus_d_out     <= BYTE_RST;
      bus_d_oe_out  <= '0;
      rd_strobe_out <= 1'b0;
      rd_dc_out     <= 1'b0;
    end else begin
      st_r          <= st_nxt;
      bus_d_out     <= dout_nxt;
      bus_d_oe_out  <= oe_nxt;
      rd_strobe_out <= rdstb_nxt;
      rd_dc_out     <= rddc_nxt;
    end
  end

  // ---------------- write path through the buffer
  assign fifo_in_valid = par_write | ser_event;
  assign fifo_in_word  = par_mode ? par_word : ser_hold_r;

  xfer_fifo #(
    .WIDTH (XFER_W),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .flush_in      (mod_rst),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in_word),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (wr_ready_in & wr_valid_out),
    .out_data_out  (fifo_out_word)
  );

  // output stage re-registers the buffer head; valid drops for one cycle per word
  logic  ov_nxt;
  xfer_t ow_nxt;
  logic  busy_nxt;

  always_comb begin
    ov_nxt   = fifo_out_valid & ~(wr_valid_out & wr_ready_in) & ~mod_rst;
    ow_nxt   = fifo_out_word;
    busy_nxt = ~fifo_in_ready;
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_valid_out        <= 1'b0;
      wr_dc_out           <= 1'b0;
      wr_data_out         <= BYTE_RST;
      busy_out            <= 1'b0;
      module_in_reset_out <= 1'b0;
    end else begin
      wr_valid_out        <= ov_nxt;
      wr_dc_out           <= ow_nxt.dc;
      wr_data_out         <= ow_nxt.data;
      busy_out            <= busy_nxt;
      module_in_reset_out <= mod_rst;
    end
  end
endmodule

`default_nettype wire

// *** lcd_port_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcd_port_assertions
  import lcd_port_pkg::*;
(
  // clock and reset
  input wire logic              clock_in,
  input wire logic              sys_rst_in,
  // host pins
  input wire logic              chip_select_low_in,
  input wire logic              chip_select_high_in,
  input wire logic              module_reset_n_in,
  input wire logic              bus_flavor_sel_in,
  input wire logic              parallel_sel_in,
  input wire logic              rd_enable_in,
  input wire logic              wr_dir_in,
  // outputs
  input wire logic [DATA_W-1:0] bus_d_oe_out,
  input wire logic              rd_strobe_out,
  input wire logic              wr_valid_out,
  input wire logic              module_in_reset_out
);
  wire logic sel = !chip_select_low_in && chip_select_high_in && parallel_sel_in && module_reset_n_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  a_oe_uniform:
    assert property (bus_d_oe_out == 8'h00 || bus_d_oe_out == 8'hFF) else $error("oe split");
  a_desel_float:
    assert property ((chip_select_low_in || !chip_select_high_in)[*5] |-> bus_d_oe_out == 8'h00)
    else $error("drives deselected");
  a_serial_float:
    assert property ((!parallel_sel_in)[*5] |-> bus_d_oe_out == 8'h00) else $error("drives in serial");
  a_sep_read:
    assert property ((sel && !bus_flavor_sel_in && !rd_enable_in)[*8] |-> bus_d_oe_out == 8'hFF)
    else $error("no read drive");
  a_en_read:
    assert property ((sel && bus_flavor_sel_in && rd_enable_in && wr_dir_in)[*8] |-> bus_d_oe_out == 8'hFF)
    else $error("no enable read drive");
  a_en_write:
    assert property ((bus_flavor_sel_in && !wr_dir_in)[*5] |-> bus_d_oe_out == 8'h00) else $error("drives on write");
  a_strobe_once:
    assert property (rd_strobe_out |-> bus_d_oe_out == 8'hFF ##1 !rd_strobe_out) else $error("bad read strobe");
  a_reset_level:
    assert property ((!module_reset_n_in)[*7] |-> module_in_reset_out && !wr_valid_out && bus_d_oe_out == 8'h00)
    else $error("reset not held");
endmodule
bind lcd_module_host_port lcd_port_assertions lcd_port_assertions_inst (.clock_in, .sys_rst_in,
  .chip_select_low_in, .chip_select_high_in, .module_reset_n_in, .bus_flavor_sel_in, .parallel_sel_in,
  .rd_enable_in, .wr_dir_in, .bus_d_oe_out, .rd_strobe_out, .wr_valid_out, .module_in_reset_out);
`default_nettype wire

// *** host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model
  import lcd_port_pkg::*;
(
  // clock
  input  wire logic              clock_in,
  // device side of the data pins
  input  wire logic [DATA_W-1:0] dev_d_in,
  input  wire logic [DATA_W-1:0] dev_oe_in,
  // host pins
  output logic                   cs_l_out = 1'b0,
  output logic                   cs_h_out = 1'b1,
  output logic                   rst_n_out = 1'b1,
  output logic                   dc_out = 1'b0,
  output logic                   flav_out = 1'b0,
  output logic                   par_out = 1'b1,
  output logic                   stb_out = 1'b1,
  output logic                   dir_out = 1'b1,
  output logic      [DATA_W-1:0] wire_d_out
);
  logic [DATA_W-1:0] host_d = 8'h00;
  assign wire_d_out = dev_oe_in[0] ? dev_d_in : host_d;
  task automatic sel(input logic cl, ch, rn);
    @(posedge clock_in);
    cs_l_out  <= cl;
    cs_h_out  <= ch;
    rst_n_out <= rn;
  endtask
  // f: enable style, rd: read; got is the wire late in the strobe
  task automatic par_xfer(input logic f, rd, c, input logic [7:0] v, output logic [7:0] got);
    @(posedge clock_in);
    flav_out <= f;
    par_out  <= 1'b1;
    dc_out   <= c;
    host_d   <= rd ? ~host_d : v;
    stb_out  <= !f;
    dir_out  <= f ? rd : 1'b1;
    repeat (4) @(posedge clock_in);
    if (f) stb_out <= 1'b1;
    else if (rd) stb_out <= 1'b0;
    else dir_out <= 1'b0;
    repeat (8) @(posedge clock_in);
    got = wire_d_out;
    stb_out <= !f;
    dir_out <= f ? rd : 1'b1;
    repeat (6) @(posedge clock_in);
    host_d  <= ~v;
    dir_out <= 1'b1;
  endtask
  // link clock runs only inside the frame
  task automatic ser_write(input logic c, input logic [7:0] v);
    @(posedge clock_in);
    par_out <= 1'b0;
    host_d  <= 8'h00;
    dc_out  <= c;
    repeat (4) @(posedge clock_in);
    #3;
    for (int i = 7; i >= 0; i--) begin
      #16 host_d[7] = v[i];
      #16 host_d[6] = 1'b1;
      #32 host_d[6] = 1'b0;
    end
    #8 host_d[7] = ~v[0];
    repeat (8) @(posedge clock_in);
  endtask
endmodule
`default_nettype wire

// *** test_lcd_module_host_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_lcd_module_host_port import lcd_port_pkg::*;;
  typedef struct packed {
    logic [1:0] m;
    logic       rd;
    logic       c;
    logic [7:0] v;
    logic [7:0] e;
  } row_t;
  logic        clock_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        wr_ready_in = 1'b0;
  logic        cl, ch, rn, dc, fl, ps, stb, dir;
  logic        wr_valid_out, wr_dc_out, rd_dc_out, busy_out, module_in_reset_out;
  logic        rd_strobe;
  int          n_strobes = 0;
  logic [7:0]  wd, dev_d, dev_oe, wr_data_out, got;
  int          mismatches = 0;
  int          n_compared = 0;
  row_t        r;
  // {mode, read, dc} nibble, byte sent, byte expected
  logic [19:0] rows [10] = '{20'h10101, 20'h0FEFE, 20'h300C3, 20'h20096, 20'h58080,
                             20'h47F7F, 20'h700C3, 20'h60096, 20'h9A5A5, 20'h83C3C};
  host_model host_model_inst (.clock_in, .dev_d_in(dev_d), .dev_oe_in(dev_oe), .cs_l_out(cl), .cs_h_out(ch),
    .rst_n_out(rn), .dc_out(dc), .flav_out(fl), .par_out(ps), .stb_out(stb), .dir_out(dir), .wire_d_out(wd));
  lcd_module_host_port #(.FIFO_WORDS(4)) lcd_module_host_port_inst (.clock_in, .sys_rst_in,
    .link_clk_in(wd[SER_CLK_BIT]), .chip_select_low_in(cl), .chip_select_high_in(ch), .module_reset_n_in(rn),
    .data_command_sel_in(dc), .bus_flavor_sel_in(fl), .parallel_sel_in(ps), .rd_enable_in(stb),
    .wr_dir_in(dir), .bus_d_in(wd), .bus_d_out(dev_d), .bus_d_oe_out(dev_oe), .wr_valid_out, .wr_ready_in,
    .wr_dc_out, .wr_data_out, .disp_data_in(8'hC3), .status_in(8'h96), .rd_strobe_out(rd_strobe), .rd_dc_out,
    .busy_out, .module_in_reset_out);
  initial begin
    forever #4 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    if (rd_strobe === 1'b1) n_strobes++;
  end
  task automatic check(input logic [8:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pop(input logic [8:0] exp);
    int k;
    k = 0;
    while (wr_valid_out !== 1'b1 && k < 40) begin
      @(posedge clock_in);
      k++;
    end
    check({8'h00, wr_valid_out}, 9'h001);
    check({wr_dc_out, wr_data_out}, exp);
    wr_ready_in <= 1'b1;
    @(posedge clock_in);
    wr_ready_in <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    foreach (rows[i]) begin
      r = rows[i];
      if (r.m == 2'd2) host_model_inst.ser_write(r.c, r.v);
      else host_model_inst.par_xfer(r.m[0], r.rd, r.c, r.v, got);
      if (r.rd) check({rd_dc_out, got}, {r.c, r.e});
      else pop({r.c, r.e});
    end
    // half-selected chip must ignore writes and reads
    host_model_inst.sel(1'b1, 1'b1, 1'b1);
    host_model_inst.par_xfer(1'b0, 1'b0, 1'b1, 8'h11, got);
    host_model_inst.sel(1'b0, 1'b0, 1'b1);
    host_model_inst.par_xfer(1'b1, 1'b0, 1'b1, 8'h22, got);
    host_model_inst.par_xfer(1'b0, 1'b1, 1'b0, 8'h00, got);
    check({1'b0, got}, 9'h022);
    check({8'h00, wr_valid_out}, 9'h000);
    // write during module reset is lost
    host_model_inst.sel(1'b0, 1'b1, 1'b0);
    host_model_inst.par_xfer(1'b0, 1'b0, 1'b0, 8'h33, got);
    check({8'h00, module_in_reset_out}, 9'h001);
    host_model_inst.sel(1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge clock_in);
    check({8'h00, wr_valid_out}, 9'h000);
    check({8'h00, module_in_reset_out}, 9'h000);
    // consumer stalls: four words fit, the fifth is dropped
    for (int i = 0; i < 5; i++) host_model_inst.par_xfer(1'b0, 1'b0, 1'b1, 8'h40 | 8'(i), got);
    check({8'h00, busy_out}, 9'h001);
    for (int i = 0; i < 4; i++) pop({1'b1, 8'h40 | 8'(i)});
    check({8'h00, wr_valid_out}, 9'h000);
    check({1'b0, 8'(n_strobes)}, 9'h004);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
